// >>> core/ubst_map.svh
// register offsets, field positions, reset values and timing constants
// assumes inclusion by bare name from the ubst design files
`ifndef UBST_MAP_SVH
`define UBST_MAP_SVH
`define UBST_OFS_TX_HOLD     4'h0
`define UBST_OFS_IRQ_EN      4'h1
`define UBST_OFS_FIFO_CTRL   4'h2
`define UBST_OFS_LINE_CTRL   4'h3
`define UBST_OFS_MODEM_CTRL  4'h4
`define UBST_OFS_STATUS      4'h5
`define UBST_OFS_ENH_FEAT    4'h6
`define UBST_OFS_DIV_LOW     4'h7
`define UBST_OFS_DIV_HIGH    4'h8
`define UBST_OFS_RX_CTRL     4'h9
`define UBST_BIT_SLEEP_EN    4
`define UBST_BIT_ENH_FUNC    4
`define UBST_BIT_DMA_MODE    3
`define UBST_BIT_FIFO_EN     0
`define UBST_BIT_BREAK       6
`define UBST_BIT_PRESCALE    7
`define UBST_LINE_CTRL_RST   8'h1D
`define UBST_OVERSAMPLE      5'h10
`define UBST_TO_EXTRA        8'h0C
`define UBST_FIFO_DEPTH      7'h40
`endif

// >>> core/ubst_pkg.sv
// types shared by the tx, sleep and timeout channel logic
// assumes the map header supplies offsets and field positions
package ubst_pkg;
  typedef enum logic [1:0] {
    UBST_AWAKE,
    UBST_ASLEEP
  } ubst_sleep_t;
  typedef enum logic [1:0] {
    UBST_TX_IDLE,
    UBST_TX_SHIFT
  } ubst_tx_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ubst_bus_t;
  typedef struct packed {
    logic       rx_byte;
    logic       rx_read;
    logic [6:0] rx_level;
    logic       irq_other;
    logic [3:0] modem_in;
  } ubst_rxside_t;
endpackage

// >>> core/ubst_top.sv
// baud generator, tx pacing, sleep control, rx timeout and break
// assumes the receive datapath reports through a rx side struct on clock
//
// Notes on behaviour
// - single dma or fifo off: send each character once written
// - block dma: hold transmit until free space reaches trigger
// - transmit trigger level from fifo control bits 5:4
// - receive trigger level from fifo control bits 7:6
// - sleep armed only with enhanced bit 4 and irq enable bit 4
// - sleep needs idle rx, empty tx, only tx-empty/timeout irqs
// - never sleep while the receive fifo holds data
// - asleep: channel and baud clocks stopped, divisor bytes frozen
// - wake on rx edge, modem input change or tx fifo write
// - timeout after 4 x word length + 12 high bits with data
// - line control bit 6 forces tx low while set
// - baud divider by 16-bit divisor, 1 to 65535
// - baud output is sixteen times the bit rate
// - prescaler divides by 4 when modem control bit 7 is set
// - divisor low byte is lsbs, high byte is msbs
// - divisor zero produces no baud clock
// - one baud tick clocks both transmitter and receiver
// - fifo control bit 3 selects single or block dma
// - reset loads modem control bit 7 with inverse of pin
// - divisor bytes keep their values through reset
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "ubst_map.svh"
module ubst_top (
  input  wire logic                  clock,        // 100 MHz
  input  wire logic                  rstn,         // async reset, low
  input  wire ubst_pkg::ubst_bus_t   bus,          // register port
  output logic [7:0]                 rdata,        // read data, next cycle
  input  wire logic                  prescale_select_pin, // strap pin
  input  wire logic                  rx_pin,       // serial input
  input  wire ubst_pkg::ubst_rxside_t rxs,         // rx datapath status
  output logic                       tx_pin,       // serial output
  output logic                       baud_tick,    // 16x sample strobe
  output logic                       rx_timeout,   // timeout flag
  output logic                       asleep,       // channel sleeping
  output logic [1:0]                 rx_trig_sel   // rx trigger field
);
  // ==========================================================
  // input synchronisers
  logic [1:0] rx_sync;
  logic [1:0] pin_sync;
  logic [1:0] next_rx_sync;
  logic [1:0] next_pin_sync;
  logic       rx_prev;
  logic       next_rx_prev;
  logic [3:0] modem_prev;
  logic [3:0] next_modem_prev;
  logic       strap_done;
  logic       next_strap_done;
  always_comb begin
    next_rx_sync    = {rx_sync[0], rx_pin};
    next_pin_sync   = {pin_sync[0], prescale_select_pin};
    next_rx_prev    = rx_sync[1];
    next_modem_prev = rxs.modem_in;
    next_strap_done = 1'b1;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_sync    <= 2'h3;
      rx_prev    <= 1'b1;
      modem_prev <= 4'h0;
      strap_done <= 1'b0;
    end else begin
      rx_sync    <= next_rx_sync;
      rx_prev    <= next_rx_prev;
      modem_prev <= next_modem_prev;
      strap_done <= next_strap_done;
    end
  end
  // strap sync keeps running through reset so the pin level has
  // settled by the first edge after release, when it is latched
  always_ff @(posedge clock) begin
    pin_sync <= next_pin_sync;
  end

  // ==========================================================
  // registers
  logic [7:0]  irq_enable_reg;
  logic [7:0]  fifo_ctrl_reg;
  logic [7:0]  line_ctrl_reg;
  logic [7:0]  modem_ctrl_reg;
  logic [7:0]  enhanced_feature_reg;
  logic [7:0]  baud_divisor_low;
  logic [7:0]  baud_divisor_high;
  logic [7:0]  next_irq_enable_reg;
  logic [7:0]  next_fifo_ctrl_reg;
  logic [7:0]  next_line_ctrl_reg;
  logic [7:0]  next_modem_ctrl_reg;
  logic [7:0]  next_enhanced_feature_reg;
  logic [7:0]  next_baud_divisor_low;
  logic [7:0]  next_baud_divisor_high;
  logic [7:0]  next_rdata;
  logic        tx_write;
  logic        sleep_q;
  logic [6:0]  tx_count;
  logic        tx_busy;
  logic        wr_dl;
  logic        wr_dh;
  assign tx_write = bus.wr && (bus.addr == `UBST_OFS_TX_HOLD);
  assign wr_dl = bus.wr && (bus.addr == `UBST_OFS_DIV_LOW) && !sleep_q;
  assign wr_dh = bus.wr && (bus.addr == `UBST_OFS_DIV_HIGH) && !sleep_q;
  always_comb begin
    next_irq_enable_reg       = irq_enable_reg;
    next_fifo_ctrl_reg        = fifo_ctrl_reg;
    next_line_ctrl_reg        = line_ctrl_reg;
    next_modem_ctrl_reg       = modem_ctrl_reg;
    next_enhanced_feature_reg = enhanced_feature_reg;
    next_rdata                = 8'h00;
    // strap is caught on the first clock after release
    if (!strap_done) begin
      next_modem_ctrl_reg[`UBST_BIT_PRESCALE] = ~pin_sync[1];
      next_enhanced_feature_reg[`UBST_BIT_PRESCALE] = ~pin_sync[1];
    end else if (bus.wr) begin
      case (bus.addr)
        `UBST_OFS_IRQ_EN:     next_irq_enable_reg = bus.wdata;
        `UBST_OFS_FIFO_CTRL:  next_fifo_ctrl_reg = bus.wdata;
        `UBST_OFS_LINE_CTRL:  next_line_ctrl_reg = bus.wdata;
        `UBST_OFS_MODEM_CTRL: next_modem_ctrl_reg = bus.wdata;
        `UBST_OFS_ENH_FEAT:   next_enhanced_feature_reg = bus.wdata;
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        `UBST_OFS_IRQ_EN:     next_rdata = irq_enable_reg;
        `UBST_OFS_FIFO_CTRL:  next_rdata = fifo_ctrl_reg;
        `UBST_OFS_LINE_CTRL:  next_rdata = line_ctrl_reg;
        `UBST_OFS_MODEM_CTRL: next_rdata = modem_ctrl_reg;
        `UBST_OFS_ENH_FEAT:   next_rdata = enhanced_feature_reg;
        `UBST_OFS_DIV_LOW:    next_rdata = baud_divisor_low;
        `UBST_OFS_DIV_HIGH:   next_rdata = baud_divisor_high;
        `UBST_OFS_STATUS:
          next_rdata = {4'h0, tx_busy, rx_timeout, sleep_q,
                        tx_count == 7'h00};
        default:              next_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_enable_reg       <= 8'h00;
      fifo_ctrl_reg        <= 8'h00;
      line_ctrl_reg        <= `UBST_LINE_CTRL_RST;
      modem_ctrl_reg       <= 8'h00;
      enhanced_feature_reg <= 8'h00;
      rdata                <= 8'h00;
    end else begin
      irq_enable_reg       <= next_irq_enable_reg;
      fifo_ctrl_reg        <= next_fifo_ctrl_reg;
      line_ctrl_reg        <= next_line_ctrl_reg;
      modem_ctrl_reg       <= next_modem_ctrl_reg;
      enhanced_feature_reg <= next_enhanced_feature_reg;
      rdata                <= next_rdata;
    end
  end

  // divisor bytes sit outside reset so a warm reset keeps the rate;
  // writes while asleep are dropped as a guard against host misuse
  always_comb begin
    next_baud_divisor_low  = wr_dl ? bus.wdata : baud_divisor_low;
    next_baud_divisor_high = wr_dh ? bus.wdata : baud_divisor_high;
  end
  always_ff @(posedge clock) begin
    baud_divisor_low  <= next_baud_divisor_low;
    baud_divisor_high <= next_baud_divisor_high;
  end

  // ==========================================================
  // sleep control
  ubst_pkg::ubst_sleep_t sleep_st;
  ubst_pkg::ubst_sleep_t next_sleep_st;
  logic armed;
  logic can_sleep;
  logic wake;
  assign armed = enhanced_feature_reg[`UBST_BIT_ENH_FUNC]
              && irq_enable_reg[`UBST_BIT_SLEEP_EN];
  assign can_sleep = armed && rx_sync[1] && (tx_count == 7'h00) && !tx_busy
                  && !rxs.irq_other
                  && (rxs.rx_level == 7'h00);
  assign wake = (rx_sync[1] != rx_prev) || (rxs.modem_in != modem_prev)
             || tx_write;
  assign sleep_q = (sleep_st == ubst_pkg::UBST_ASLEEP);
  always_comb begin
    next_sleep_st = sleep_st;
    case (sleep_st)
      ubst_pkg::UBST_AWAKE:
        if (can_sleep && !wake) next_sleep_st = ubst_pkg::UBST_ASLEEP;
      ubst_pkg::UBST_ASLEEP:
        if (wake || !armed) next_sleep_st = ubst_pkg::UBST_AWAKE;
      default: next_sleep_st = ubst_pkg::UBST_AWAKE;
    endcase
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sleep_st <= ubst_pkg::UBST_AWAKE;
      asleep   <= 1'b0;
    end else begin
      sleep_st <= next_sleep_st;
      asleep   <= (next_sleep_st == ubst_pkg::UBST_ASLEEP);
    end
  end

  // ==========================================================
  // prescaler and baud divider
  logic        run;
  logic [1:0]  pre_cnt;
  logic [1:0]  next_pre_cnt;
  logic        pre_tick;
  logic [15:0] divisor;
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic        next_baud_tick;
  assign run = !sleep_q;
  assign divisor = {baud_divisor_high, baud_divisor_low};
  assign pre_tick = modem_ctrl_reg[`UBST_BIT_PRESCALE]
                  ? (pre_cnt == 2'h3) : 1'b1;
  always_comb begin
    next_pre_cnt   = pre_cnt;
    next_div_cnt   = div_cnt;
    next_baud_tick = 1'b0;
    if (run) begin
      next_pre_cnt = pre_cnt + 2'h1;
      if (divisor == 16'h0000) begin
        next_div_cnt = 16'h0000;
      end else if (pre_tick) begin
        if (div_cnt >= divisor - 16'h0001) begin
          next_div_cnt   = 16'h0000;
          next_baud_tick = 1'b1;
        end else begin
          next_div_cnt = div_cnt + 16'h0001;
        end
      end
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_cnt   <= 2'h0;
      div_cnt   <= 16'h0000;
      baud_tick <= 1'b0;
    end else begin
      pre_cnt   <= next_pre_cnt;
      div_cnt   <= next_div_cnt;
      baud_tick <= next_baud_tick;
    end
  end

  // ==========================================================
  // transmit pacing and shifter
  // a simple occupancy count stands in for the fifo datapath
  ubst_pkg::ubst_tx_t tx_st;
  ubst_pkg::ubst_tx_t next_tx_st;
  logic [6:0] next_tx_count;
  logic [6:0] tx_trig;
  logic [6:0] tx_space;
  logic [3:0] os_cnt;
  logic [3:0] next_os_cnt;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [3:0] frame_bits;
  logic       bit_tick;
  logic       block_mode;
  logic       start_ok;
  logic       tx_level;
  logic       next_tx_level;
  logic       next_tx_pin;
  assign block_mode = fifo_ctrl_reg[`UBST_BIT_DMA_MODE]
                   && fifo_ctrl_reg[`UBST_BIT_FIFO_EN];
  always_comb begin
    case (fifo_ctrl_reg[5:4])
      2'h0:    tx_trig = 7'h08;
      2'h1:    tx_trig = 7'h10;
      2'h2:    tx_trig = 7'h20;
      default: tx_trig = 7'h38;
    endcase
  end
  assign tx_space = `UBST_FIFO_DEPTH - tx_count;
  assign start_ok = block_mode ? (tx_space >= tx_trig)
                               : 1'b1;
  assign bit_tick = baud_tick && (os_cnt == 4'hF);
  // start + data + parity + stop from the line control word
  assign frame_bits = 4'h7 + {2'h0, line_ctrl_reg[1:0]}
                    + {3'h0, line_ctrl_reg[3]} + {3'h0, line_ctrl_reg[2]};
  assign tx_busy = (tx_st == ubst_pkg::UBST_TX_SHIFT);
  always_comb begin
    next_tx_st    = tx_st;
    next_tx_count = tx_count;
    next_bit_cnt  = bit_cnt;
    next_tx_level = tx_level;
    next_os_cnt   = baud_tick ? os_cnt + 4'h1 : os_cnt;
    if (tx_write && tx_count != `UBST_FIFO_DEPTH)
      next_tx_count = tx_count + 7'h01;
    case (tx_st)
      ubst_pkg::UBST_TX_IDLE: begin
        next_tx_level = 1'b1;
        if (tx_count != 7'h00 && start_ok && bit_tick) begin
          next_tx_st    = ubst_pkg::UBST_TX_SHIFT;
          next_tx_count = next_tx_count - 7'h01;
          next_bit_cnt  = 4'h0;
          next_tx_level = 1'b0;
        end
      end
      ubst_pkg::UBST_TX_SHIFT:
        if (bit_tick) begin
          next_bit_cnt  = bit_cnt + 4'h1;
          next_tx_level = 1'b1;
          if (bit_cnt + 4'h1 >= frame_bits)
            next_tx_st = ubst_pkg::UBST_TX_IDLE;
        end
      default: next_tx_st = ubst_pkg::UBST_TX_IDLE;
    endcase
    next_tx_pin = next_tx_level
               && !next_line_ctrl_reg[`UBST_BIT_BREAK];
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_st    <= ubst_pkg::UBST_TX_IDLE;
      tx_count <= 7'h00;
      os_cnt   <= 4'h0;
      bit_cnt  <= 4'h0;
      tx_level <= 1'b1;
      tx_pin   <= 1'b1;
    end else begin
      tx_st    <= next_tx_st;
      tx_count <= next_tx_count;
      os_cnt   <= next_os_cnt;
      bit_cnt  <= next_bit_cnt;
      tx_level <= next_tx_level;
      tx_pin   <= next_tx_pin;
    end
  end

  // ==========================================================
  // receive timeout
  logic [7:0] to_cnt;
  logic [7:0] next_to_cnt;
  logic [7:0] to_limit;
  logic       next_rx_timeout;
  logic [1:0] next_rx_trig_sel;
  // word length kept four bits wide so an 8-bit word does not wrap
  assign to_limit = {2'h0, 4'h5 + {2'h0, line_ctrl_reg[1:0]}, 2'h0}
                  + `UBST_TO_EXTRA;
  always_comb begin
    next_to_cnt      = to_cnt;
    next_rx_timeout  = rx_timeout;
    next_rx_trig_sel = fifo_ctrl_reg[7:6];
    if (rxs.rx_byte || rxs.rx_read || !rx_sync[1]
        || rxs.rx_level == 7'h00) begin
      next_to_cnt     = 8'h00;
      next_rx_timeout = 1'b0;
    end else if (bit_tick && to_cnt < to_limit) begin
      next_to_cnt = to_cnt + 8'h01;
      if (to_cnt + 8'h01 == to_limit) next_rx_timeout = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      to_cnt      <= 8'h00;
      rx_timeout  <= 1'b0;
      rx_trig_sel <= 2'h0;
    end else begin
      to_cnt      <= next_to_cnt;
      rx_timeout  <= next_rx_timeout;
      rx_trig_sel <= next_rx_trig_sel;
    end
  end
endmodule

// >>> dv/ubst_chk.sv
// checker for the ubst_top ports: break, read data, sleep, timeout
// assumes a bind from the bench top file and the map header on the path
`timescale 1ns/1ps
`include "ubst_map.svh"
module ubst_chk (
  input wire logic                   clock,       // channel clock
  input wire logic                   rstn,        // async reset, low
  input wire ubst_pkg::ubst_bus_t    bus,         // register port
  input wire logic [7:0]             rdata,       // read data
  input wire logic                   rx_pin,      // serial input
  input wire ubst_pkg::ubst_rxside_t rxs,         // rx status
  input wire logic                   tx_pin,      // serial output
  input wire logic                   baud_tick,   // 16x strobe
  input wire logic                   rx_timeout,  // timeout flag
  input wire logic                   asleep,      // sleeping
  input wire logic [1:0]             rx_trig_sel  // rx trigger field
);
  // ==========================================================
  // sleep arming tracked from writes, since it is not a port
  logic ier_sl;
  logic enh_sl;
  logic next_ier_sl;
  logic next_enh_sl;
  logic fcr_wr;
  logic tx_wr;
  assign fcr_wr = bus.wr && bus.addr == `UBST_OFS_FIFO_CTRL;
  assign tx_wr  = bus.wr && bus.addr == `UBST_OFS_TX_HOLD;
  always_comb begin
    next_ier_sl = ier_sl;
    next_enh_sl = enh_sl;
    if (bus.wr && bus.addr == `UBST_OFS_IRQ_EN)
      next_ier_sl = bus.wdata[`UBST_BIT_SLEEP_EN];
    if (bus.wr && bus.addr == `UBST_OFS_ENH_FEAT)
      next_enh_sl = bus.wdata[`UBST_BIT_ENH_FUNC];
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ier_sl <= 1'b0;
      enh_sl <= 1'b0;
    end else begin
      ier_sl <= next_ier_sl;
      enh_sl <= next_enh_sl;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_break_low: assert property (
    bus.wr && bus.addr == `UBST_OFS_LINE_CTRL
    && bus.wdata[`UBST_BIT_BREAK] |-> ##2 !tx_pin)
    else $error("break write did not pull tx low");
  chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  chk_trig_src: assert property (
    $changed(rx_trig_sel) |-> $past(fcr_wr) || $past(fcr_wr, 2))
    else $error("rx trigger changed without fifo control write");
  chk_sleep_freeze: assert property (
    asleep && $past(asleep) |-> !baud_tick)
    else $error("baud tick while asleep");
  chk_sleep_cond: assert property (
    $rose(asleep) |-> $past(rxs.rx_level) == 7'h00 && !$past(rxs.irq_other))
    else $error("sleep entered with data or interrupt pending");
  chk_sleep_armed: assert property (
    $rose(asleep) |-> ier_sl && enh_sl)
    else $error("sleep entered while not armed");
  chk_wake_modem: assert property (
    asleep && $changed(rxs.modem_in) |-> ##[1:3] !asleep)
    else $error("no wake on modem input change");
  chk_wake_rx: assert property (
    asleep && $changed(rx_pin) |-> ##[1:6] !asleep)
    else $error("no wake on rx edge");
  chk_wake_tx: assert property (
    asleep && tx_wr |-> ##[1:3] !asleep)
    else $error("no wake on tx hold write");
  chk_to_restart: assert property (
    rxs.rx_read |-> ##[1:2] !rx_timeout)
    else $error("timeout not cleared by fifo read");
endmodule

// >>> dv/ubst_partner.sv
// remote serial end: sends a frame on request, counts tx start bits
// assumes the bench clock and a bit time in clocks given by parameter
`timescale 1ns/1ps
module ubst_partner #(
  parameter int BIT_CLKS = 16  // clocks per bit at bench divisor
) (
  input  wire logic clock,     // bench clock
  input  wire logic send,      // pulse: send one frame
  input  wire logic tx_pin,    // device serial out
  output logic      rx_pin,    // device serial in
  output int        starts     // falling edges seen on tx_pin
);
  logic       tx_q;
  logic [9:0] frame;
  initial begin
    rx_pin = 1'b1;
    starts = 0;
    tx_q   = 1'b1;
    frame  = {1'b1, 8'hA5, 1'b0};
  end
  always @(posedge clock) begin
    tx_q <= tx_pin;
    if (tx_q && !tx_pin)
      starts <= starts + 1;
  end
  // line idles high between frames; its edges wake a sleeping channel
  always @(posedge clock) begin
    if (send) begin
      for (int i = 0; i < 10; i++) begin
        rx_pin <= frame[i];
        repeat (BIT_CLKS) @(posedge clock);
      end
    end
  end
endmodule

// >>> dv/ubst_tb.sv
// bench top for ubst_top: register tasks, serial partner, checker bind
// assumes ubst_pkg compiled first and core/ on the include path
`timescale 1ns/1ps
`include "ubst_map.svh"
module testbench;
  logic                   clock = 1'b0;
  logic                   rstn;
  ubst_pkg::ubst_bus_t    bus;
  logic [7:0]             rdata;
  logic                   pin;
  logic                   rx_pin;
  ubst_pkg::ubst_rxside_t rxs;
  logic                   tx_pin;
  logic                   baud_tick;
  logic                   rx_timeout;
  logic                   asleep;
  logic [1:0]             rx_trig_sel;
  logic                   send;
  int                     starts;
  int                     mismatches = 0;
  int                     comparisons = 0;
  int                     n;
  always #5 clock = ~clock;
  ubst_top i_dut (.clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata),
    .prescale_select_pin(pin), .rx_pin(rx_pin), .rxs(rxs),
    .tx_pin(tx_pin), .baud_tick(baud_tick), .rx_timeout(rx_timeout),
    .asleep(asleep), .rx_trig_sel(rx_trig_sel));
  ubst_partner #(.BIT_CLKS(16)) i_far (.clock(clock), .send(send),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .starts(starts));
  // ==========================================================
  // tasks
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [3:0] a,
                    input logic [7:0] exp);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask
  // a bound that runs out ends the run at once
  task automatic wait_lvl(input string what, ref logic s,
                          input logic v, input int lim);
    #1;
    for (int i = 0; i < lim && s !== v; i++) begin
      @(posedge clock);
      #1;
    end
    chk(what, {15'h0, v}, {15'h0, s});
    if (s !== v)
      test_done();
  endtask
  task automatic gap(input string what, input int exp);
    int k;
    wait_lvl(what, baud_tick, 1'b1, 600);
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (baud_tick !== 1'b1 && k < 600);
    chk(what, 16'(exp), 16'(k));
    if (k >= 600)
      test_done();
  endtask
  task automatic ticks(input string what, input int clks, input int exp);
    int k;
    k = 0;
    repeat (clks) begin
      @(posedge clock);
      #1;
      if (baud_tick === 1'b1)
        k++;
    end
    chk(what, 16'(exp), 16'(k));
  endtask
  task automatic do_reset(input logic p);
    pin  <= p;
    rstn <= 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  // ==========================================================
  // sequence
  initial begin
    bus  <= '0;
    rxs  <= '0;
    send <= 1'b0;
    do_reset(1'b0);
    rd("line ctrl rst", `UBST_OFS_LINE_CTRL, `UBST_LINE_CTRL_RST);
    rd("modem rst", `UBST_OFS_MODEM_CTRL, 8'h80);
    wr(4'h9, 8'hFF);
    rd("unmapped", 4'h9, 8'h00);
    wr(`UBST_OFS_DIV_HIGH, 8'h00);
    wr(`UBST_OFS_DIV_LOW, 8'h00);
    ticks("no ticks at zero", 100, 0);
    wr(`UBST_OFS_DIV_LOW, 8'h02);
    gap("gap div2 pre4", 8);
    rd("div low", `UBST_OFS_DIV_LOW, 8'h02);
    wr(`UBST_OFS_MODEM_CTRL, 8'h00);
    gap("gap div2 pre1", 2);
    wr(`UBST_OFS_DIV_HIGH, 8'h01);
    wr(`UBST_OFS_DIV_LOW, 8'h00);
    gap("gap div256", 256);
    wr(`UBST_OFS_DIV_LOW, 8'h01);
    wr(`UBST_OFS_DIV_HIGH, 8'h00);
    do_reset(1'b1);
    rd("div kept", `UBST_OFS_DIV_LOW, 8'h01);
    rd("modem pin hi", `UBST_OFS_MODEM_CTRL, 8'h00);
    gap("gap div1", 1);
    for (int i = 0; i < 4; i++) begin
      wr(`UBST_OFS_FIFO_CTRL, {i[1:0], 6'h00});
      repeat (2) @(posedge clock);
      #1;
      chk("rx trigger", {14'h0, i[1:0]}, {14'h0, rx_trig_sel});
    end
    wr(`UBST_OFS_FIFO_CTRL, 8'h00);
    wr(`UBST_OFS_LINE_CTRL, 8'h43);
    repeat (20) @(posedge clock);
    #1;
    chk("break held", 16'h0, {15'h0, tx_pin});
    wr(`UBST_OFS_LINE_CTRL, 8'h03);
    wait_lvl("break off", tx_pin, 1'b1, 5);
    n = starts;
    wr(`UBST_OFS_TX_HOLD, 8'h55);
    wait_lvl("tx start", tx_pin, 1'b0, 40);
    repeat (200) @(posedge clock);
    chk("one char", 16'(n + 1), 16'(starts));
    // no baud ticks while the block is queued, so nothing starts early
    wr(`UBST_OFS_DIV_LOW, 8'h00);
    wr(`UBST_OFS_FIFO_CTRL, 8'h39);
    for (int i = 0; i < 9; i++)
      wr(`UBST_OFS_TX_HOLD, 8'hA0);
    wr(`UBST_OFS_DIV_LOW, 8'h01);
    repeat (100) @(posedge clock);
    chk("block held", 16'(n + 1), 16'(starts));
    wr(`UBST_OFS_FIFO_CTRL, 8'h29);
    repeat (1700) @(posedge clock);
    chk("block sent", 16'(n + 10), 16'(starts));
    wr(`UBST_OFS_FIFO_CTRL, 8'h00);
    // 8 bit words: 4 x 8 + 12 = 44 bit periods of 16 clocks
    rxs.rx_level <= 7'h01;
    repeat (680) @(posedge clock);
    #1;
    chk("timeout early", 16'h0, {15'h0, rx_timeout});
    wait_lvl("timeout", rx_timeout, 1'b1, 60);
    @(posedge clock);
    rxs.rx_read <= 1'b1;
    @(posedge clock);
    rxs.rx_read <= 1'b0;
    wait_lvl("timeout clear", rx_timeout, 1'b0, 3);
    wr(`UBST_OFS_ENH_FEAT, 8'h10);
    wr(`UBST_OFS_IRQ_EN, 8'h10);
    ticks("awake with data", 30, 30);
    chk("no sleep data", 16'h0, {15'h0, asleep});
    rxs.rx_level  <= 7'h00;
    rxs.irq_other <= 1'b1;
    repeat (30) @(posedge clock);
    chk("no sleep irq", 16'h0, {15'h0, asleep});
    rxs.irq_other <= 1'b0;
    wait_lvl("sleep", asleep, 1'b1, 20);
    ticks("frozen", 40, 0);
    send <= 1'b1;
    @(posedge clock);
    send <= 1'b0;
    wait_lvl("rx wake", asleep, 1'b0, 20);
    wait_lvl("resleep rx", asleep, 1'b1, 400);
    repeat (160) @(posedge clock);
    wait_lvl("asleep after frame", asleep, 1'b1, 20);
    rxs.modem_in <= 4'h5;
    wait_lvl("modem wake", asleep, 1'b0, 10);
    wait_lvl("resleep modem", asleep, 1'b1, 40);
    wr(`UBST_OFS_TX_HOLD, 8'h3C);
    wait_lvl("tx wake", asleep, 1'b0, 10);
    wait_lvl("tx after wake", tx_pin, 1'b0, 40);
    wait_lvl("resleep tx", asleep, 1'b1, 300);
    wr(`UBST_OFS_IRQ_EN, 8'h00);
    wait_lvl("disarm wake", asleep, 1'b0, 10);
    test_done();
  end
endmodule
bind ubst_top ubst_chk i_chk (.clock(clock), .rstn(rstn), .bus(bus),
  .rdata(rdata), .rx_pin(rx_pin), .rxs(rxs), .tx_pin(tx_pin),
  .baud_tick(baud_tick), .rx_timeout(rx_timeout), .asleep(asleep),
  .rx_trig_sel(rx_trig_sel));
